// ===== design/rca_axil.sv
// axi4-lite slave front end for the converter control registers
// assumes the register file decodes addresses and answers within the same cycle
`include "rca_params.svh"

module rca_axil #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output rca_pkg::rca_wr_s wr,
	input wire logic wr_ok,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);

	if (ADDR_W < 5 || ADDR_W > 8) begin : g_chk
		$error("rca_axil: ADDR_W must be 5 to 8");
	end

	logic aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic [7:0] aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic wr_fire, ar_fire;

	assign s_axi_awready = !aw_full_q && !bvalid_q;
	assign s_axi_wready = !w_full_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	// both halves held, so the commit happens one cycle after the later one is taken
	assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
	assign ar_fire = s_axi_arvalid && !rvalid_q;
	assign wr = '{en: wr_fire, addr: aw_addr_q, data: w_data_q, strb: w_strb_q};
	assign rd_addr = 8'(s_axi_araddr);

	always_comb begin
		aw_full_d = aw_full_q;
		aw_addr_d = aw_addr_q;
		w_full_d = w_full_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_d = 1'b1;
			aw_addr_d = 8'(s_axi_awaddr);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_ok ? `RCA_RESP_OKAY : `RCA_RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (ar_fire) begin
			rvalid_d = 1'b1;
			rdata_d = rd_ok ? rd_data : 32'h0000_0000;
			rresp_d = rd_ok ? `RCA_RESP_OKAY : `RCA_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_full_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rresp_q <= 2'h0;
			rdata_q <= 32'h0000_0000;
		end else begin
			aw_full_q <= aw_full_d;
			aw_addr_q <= aw_addr_d;
			w_full_q <= w_full_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

endmodule

// ===== design/rca_ctrl.sv
// control of a two-channel rc oscillation converter: gate counters, pin drive, interrupt
// assumes the analog oscillator returns its clock on rc_osc_clock, async to clk
// Operation
// - decade counter of clk, limit 79999
// - 14-bit binary counter of oscillation clock
// - overflow flags; selected overflow raises interrupt
// - select bit picks decade or binary source
// - interrupt vector address is 02F
// - run bit starts or halts everything
// - four-bit mode field selects pins
// - modes 0 and 7 count external inputs
// - channel zero modes 1 to 4
// - channel one modes 5 and 6
// - drive only selected pair, opposite polarity
// - never both oscillation channels together
// - counting waits for synchronised count-on
// - gate overflow clears run, stops counting
`include "rca_params.svh"

module rca_ctrl #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rc_osc_clock,
	input wire logic ext_clock_in_zero,
	input wire logic ext_clock_in_one,
	output rca_pkg::rca_pins_s osc_pins,
	output logic converter_irq,
	output logic [11:0] irq_vector
);

	////////////////////////////////////////////////////////////////////////////
	// register front end

	rca_pkg::rca_wr_s wr;
	logic wr_ok, rd_ok;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;

	rca_axil #(.ADDR_W(ADDR_W)) u_axil (
		.clk(clk),
		.reset_n(reset_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr(wr),
		.wr_ok(wr_ok),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == `RCA_OFS_RUN_SEL) || (a == `RCA_OFS_MODE) ||
			(a == `RCA_OFS_CNT_DEC) || (a == `RCA_OFS_CNT_BIN) ||
			(a == `RCA_OFS_IRQ_STAT) || (a == `RCA_OFS_IRQ_CLR) ||
			(a == `RCA_OFS_IRQ_EN) || (a == `RCA_OFS_VECTOR);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input rca_pkg::rca_wr_s w);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (w.strb[i]) begin
				merge[i*8 +: 8] = w.data[i*8 +: 8];
			end
		end
	endfunction

	// one decade step per digit; the top digit counts to 7 only, giving 79999
	function automatic logic [`RCA_DEC_W:0] dec_inc(input logic [`RCA_DEC_W-1:0] v);
		logic [`RCA_DEC_W-1:0] r;
		logic c;
		r = v;
		c = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (c) begin
				if (r[i*4 +: 4] == 4'h9) begin
					r[i*4 +: 4] = 4'h0;
				end else begin
					r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
					c = 1'b0;
				end
			end
		end
		if (c) begin
			if (r[18:16] == 3'h7) begin
				r[18:16] = 3'h0;
			end else begin
				r[18:16] = r[18:16] + 3'h1;
				c = 1'b0;
			end
		end
		dec_inc = {c, r};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers and oscillation clock edge

	logic [2:0] sync1_q, sync2_q;
	logic cnt_clk_prev_q, cnt_clk_prev_d;
	logic cnt_clk_lvl, cnt_clk_rise;
	logic osc_phase;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {ext_clock_in_one, ext_clock_in_zero, rc_osc_clock};
			sync2_q <= sync1_q;
		end
	end

	logic run_q, run_d, sel_q, sel_d;
	logic [3:0] mode_q, mode_d;

	assign osc_phase = sync2_q[0];

	// external input in modes 0 and 7
	always_comb begin
		if (mode_q == `RCA_MODE_EXT0) begin
			cnt_clk_lvl = sync2_q[1];
		end else if (mode_q == `RCA_MODE_EXT1) begin
			cnt_clk_lvl = sync2_q[2];
		end else if (mode_q[`RCA_BIT_MODE_TOP]) begin
			cnt_clk_lvl = 1'b0;
		end else begin
			cnt_clk_lvl = osc_phase;
		end
		cnt_clk_prev_d = cnt_clk_lvl;
	end

	assign cnt_clk_rise = cnt_clk_lvl && !cnt_clk_prev_q;

	////////////////////////////////////////////////////////////////////////////
	// pin drive

	// mode field picks the pin pair
	function automatic logic [13:0] pin_pair(input logic [3:0] m);
		logic [6:0] res, cap;
		res = 7'h00;
		cap = 7'h00;
		case (m)
			4'h1: begin
				res[rca_pkg::PIN_CH0_REF_RES] = 1'b1;
				cap[rca_pkg::PIN_CH0_REF_CAP] = 1'b1;
			end
			4'h2: begin
				res[rca_pkg::PIN_CH0_SENS_RES] = 1'b1;
				cap[rca_pkg::PIN_CH0_REF_CAP] = 1'b1;
			end
			4'h3: begin
				res[rca_pkg::PIN_CH0_REF2] = 1'b1;
				cap[rca_pkg::PIN_CH0_REF_CAP] = 1'b1;
			end
			4'h4: begin
				res[rca_pkg::PIN_CH0_REF_RES] = 1'b1;
				cap[rca_pkg::PIN_CH0_REF2] = 1'b1;
			end
			4'h5: begin
				res[rca_pkg::PIN_CH1_REF_RES] = 1'b1;
				cap[rca_pkg::PIN_CH1_CAP] = 1'b1;
			end
			4'h6: begin
				res[rca_pkg::PIN_CH1_SENS_RES] = 1'b1;
				cap[rca_pkg::PIN_CH1_CAP] = 1'b1;
			end
			default: begin
				res = 7'h00;
				cap = 7'h00;
			end
		endcase
		pin_pair = {res, cap};
	endfunction

	logic [13:0] pair;
	logic [6:0] out_d, oe_d, out_q, oe_q;

	assign pair = pin_pair(mode_q);

	// only the pair, opposite polarity; one pair at most means one channel
	always_comb begin
		oe_d = run_q ? (pair[13:7] | pair[6:0]) : 7'h00;
		out_d = ({7{osc_phase}} & pair[13:7]) | ({7{!osc_phase}} & pair[6:0]);
	end

	assign osc_pins = '{out: out_q, oe: oe_q};

	////////////////////////////////////////////////////////////////////////////
	// control, counters and interrupt

	logic cnt_on_q, cnt_on_d;
	logic [`RCA_DEC_W-1:0] cnt_dec_q, cnt_dec_d;
	logic [`RCA_BIN_W-1:0] cnt_bin_q, cnt_bin_d;
	logic [1:0] stat_q, stat_d, en_q, en_d, ev;
	logic [`RCA_DEC_W:0] dec_next;
	logic counting, ovf_dec, ovf_bin, gate_ovf;

	assign counting = run_q && cnt_on_q;
	assign dec_next = dec_inc(cnt_dec_q);
	// decade counter carries out past 79999
	assign ovf_dec = counting && dec_next[`RCA_DEC_W];
	// binary counter carries out past 3FFF
	assign ovf_bin = counting && cnt_clk_rise && (cnt_bin_q == `RCA_BIN_MAX);
	// select bit chooses the gate counter
	assign gate_ovf = sel_q ? ovf_bin : ovf_dec;

	always_comb begin
		run_d = run_q;
		sel_d = sel_q;
		mode_d = mode_q;
		cnt_dec_d = cnt_dec_q;
		cnt_bin_d = cnt_bin_q;
		en_d = en_q;
		// count-on follows the run bit one step later
		cnt_on_d = run_q && !gate_ovf;
		if (counting) begin
			cnt_dec_d = dec_next[`RCA_DEC_W-1:0];
			if (cnt_clk_rise) begin
				cnt_bin_d = cnt_bin_q + 14'h0001;
			end
		end
		if (wr.en) begin
			if (wr.addr == `RCA_OFS_RUN_SEL) begin
				{sel_d, run_d} = 2'(merge(32'h0000_0000, wr));
			end else if (wr.addr == `RCA_OFS_MODE) begin
				mode_d = 4'(merge({28'h0000000, mode_q}, wr));
			end else if (wr.addr == `RCA_OFS_CNT_DEC && !run_q) begin
				cnt_dec_d = `RCA_DEC_W'(merge({13'h0000, cnt_dec_q}, wr));
			end else if (wr.addr == `RCA_OFS_CNT_BIN && !run_q) begin
				cnt_bin_d = `RCA_BIN_W'(merge({18'h00000, cnt_bin_q}, wr));
			end else if (wr.addr == `RCA_OFS_IRQ_EN) begin
				en_d = 2'(merge({30'h00000000, en_q}, wr));
			end
		end
		// gate overflow ends the run over any write this cycle
		if (gate_ovf) begin
			run_d = 1'b0;
			cnt_on_d = 1'b0;
		end
	end

	// each counter sets its own sticky flag; set wins over clear
	always_comb begin
		ev = 2'h0;
		ev[`RCA_BIT_OVF_DEC] = ovf_dec;
		ev[`RCA_BIT_OVF_BIN] = ovf_bin;
		stat_d = stat_q;
		if (wr.en && wr.addr == `RCA_OFS_IRQ_CLR) begin
			stat_d = stat_q & ~2'(merge(32'h0000_0000, wr));
		end
		stat_d = stat_d | ev;
	end

	// interrupt from the selected counter's flag
	assign converter_irq = |(stat_q & en_q & (sel_q ? 2'h2 : 2'h1));
	assign irq_vector = `RCA_IRQ_VECTOR;

	assign wr_ok = addr_known(wr.addr);
	assign rd_ok = addr_known(rd_addr);

	always_comb begin
		rd_data = 32'h0000_0000;
		if (rd_addr == `RCA_OFS_RUN_SEL) begin
			rd_data[1:0] = {sel_q, run_q};
		end else if (rd_addr == `RCA_OFS_MODE) begin
			rd_data[3:0] = mode_q;
		end else if (rd_addr == `RCA_OFS_CNT_DEC) begin
			rd_data[`RCA_DEC_W-1:0] = cnt_dec_q;
		end else if (rd_addr == `RCA_OFS_CNT_BIN) begin
			rd_data[`RCA_BIN_W-1:0] = cnt_bin_q;
		end else if (rd_addr == `RCA_OFS_IRQ_STAT) begin
			rd_data[1:0] = stat_q;
		end else if (rd_addr == `RCA_OFS_IRQ_EN) begin
			rd_data[1:0] = en_q;
		end else if (rd_addr == `RCA_OFS_VECTOR) begin
			rd_data[11:0] = `RCA_IRQ_VECTOR;
		end
	end

	// reset halts conversion with pins released
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			{sel_q, run_q} <= `RCA_RST_RUN_SEL;
			mode_q <= `RCA_RST_MODE;
			cnt_on_q <= 1'b0;
			cnt_clk_prev_q <= 1'b0;
			cnt_dec_q <= 19'h0_0000;
			cnt_bin_q <= 14'h0000;
			stat_q <= `RCA_RST_IRQ;
			en_q <= `RCA_RST_IRQ;
			out_q <= 7'h00;
			oe_q <= 7'h00;
		end else begin
			sel_q <= sel_d;
			run_q <= run_d;
			mode_q <= mode_d;
			cnt_on_q <= cnt_on_d;
			cnt_clk_prev_q <= cnt_clk_prev_d;
			cnt_dec_q <= cnt_dec_d;
			cnt_bin_q <= cnt_bin_d;
			stat_q <= stat_d;
			en_q <= en_d;
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end

endmodule

// ===== design/rca_params.svh
// constants of the rc oscillation converter control block: offsets, fields, limits
// assumes byte addresses on a 32-bit register bus, one register per aligned word
`ifndef RCA_PARAMS_SVH
`define RCA_PARAMS_SVH

`define RCA_OFS_RUN_SEL 8'h00
`define RCA_OFS_MODE 8'h04
`define RCA_OFS_CNT_DEC 8'h08
`define RCA_OFS_CNT_BIN 8'h0C
`define RCA_OFS_IRQ_STAT 8'h10
`define RCA_OFS_IRQ_CLR 8'h14
`define RCA_OFS_IRQ_EN 8'h18
`define RCA_OFS_VECTOR 8'h1C

`define RCA_BIT_RUN 0
`define RCA_BIT_SEL 1
`define RCA_BIT_MODE_TOP 3
`define RCA_BIT_OVF_DEC 0
`define RCA_BIT_OVF_BIN 1

`define RCA_RST_RUN_SEL 2'h0
`define RCA_RST_MODE 4'h0
`define RCA_RST_IRQ 2'h0

`define RCA_DEC_W 19
`define RCA_DEC_MAX 19'h7_9999
`define RCA_BIN_W 14
`define RCA_BIN_MAX 14'h3FFF
`define RCA_IRQ_VECTOR 12'h02F

`define RCA_MODE_EXT0 4'h0
`define RCA_MODE_EXT1 4'h7

`define RCA_RESP_OKAY 2'h0
`define RCA_RESP_SLVERR 2'h2

`endif

// ===== design/rca_pkg.sv
// types shared by the converter control block and its register front end
// assumes rca_params.svh supplies every numeric constant
package rca_pkg;

	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} rca_wr_s;

	// oscillator pins in a fixed order, one bit each
	typedef enum logic [2:0] {
		PIN_CH0_REF_RES = 3'h0,
		PIN_CH0_SENS_RES = 3'h1,
		PIN_CH0_REF2 = 3'h2,
		PIN_CH0_REF_CAP = 3'h3,
		PIN_CH1_REF_RES = 3'h4,
		PIN_CH1_SENS_RES = 3'h5,
		PIN_CH1_CAP = 3'h6
	} rca_pin_e;

	typedef struct packed {
		logic [6:0] out;
		logic [6:0] oe;
	} rca_pins_s;

endpackage

// ===== verification/rca_ctrl_chk.sv
// assertions on the ports of the converter control block
// assumes one clock domain; bound into rca_ctrl at the foot of this file
module rca_ctrl_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire rca_pkg::rca_pins_s osc_pins,
	input wire logic converter_irq,
	input wire logic [11:0] irq_vector
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [6:0] drv;
	assign drv = osc_pins.out & osc_pins.oe;
	////////////////////////////////////////////////////////////////////////////////
	a_vector_fixed: assert property (irq_vector == 12'h02F)
		else $error("interrupt vector wrong");
	a_pair_only: assert property ($countones(osc_pins.oe) inside {0, 2})
		else $error("wrong number of driven pins");
	a_one_channel: assert property (!(|osc_pins.oe[3:0] && |osc_pins.oe[6:4]))
		else $error("both channels driven");
	a_pair_opposite: assert property ($countones(osc_pins.oe) == 2 |-> $countones(drv) == 1)
		else $error("driven pair not in opposite polarity");
	a_reset_quiet: assert property ($rose(reset_n) |-> osc_pins.oe == 7'h00)
		else $error("pins driven after reset");
	a_halt_releases: assert property ($rose(converter_irq) |-> ##[0:3] osc_pins.oe == 7'h00)
		else $error("pins still driven after gate overflow");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_block: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("read accepted while answer pending");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	a_resp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer not released");
	a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not released");
	c_irq: cover property ($rose(converter_irq));
	c_pair: cover property ($countones(osc_pins.oe) == 2);
	c_ch_one: cover property (osc_pins.oe[4] && osc_pins.oe[6]);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind rca_ctrl rca_ctrl_chk u_chk (.clk(clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.osc_pins(osc_pins), .converter_irq(converter_irq), .irq_vector(irq_vector));

// ===== verification/rca_ctrl_test.sv
// self-checking bench of the converter control block over axi4-lite
// assumes rca_rc_net answers at the pins; external clocks come from a divider here
`include "rca_params.svh"
module rca_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
	logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready, ext0, ext1;
	logic awready, wready, bvalid, arready, rvalid, irq, osc;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d, dc;
	logic [1:0] bresp, rresp, r;
	logic [11:0] vec;
	logic [3:0] div;
	rca_pkg::rca_pins_s pins;
	int bad_count, num_checks, i;
	rca_ctrl uut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rc_osc_clock(osc), .ext_clock_in_zero(ext0), .ext_clock_in_one(ext1), .osc_pins(pins),
		.converter_irq(irq), .irq_vector(vec));
	rca_rc_net net (.osc_pins(pins), .rc_osc_clock(osc));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		div <= reset_n ? div + 4'h1 : 4'h0;
		ext0 <= div[2];
		ext1 <= div[3];
	end
	////////////////////////////////////////////////////////////////////////////////
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task timeout;
		bad_count++;
		stop_test;
	endtask
	// each task starts on a fresh edge so no signal is assigned twice in one step
	task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int k;
		@(posedge clk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				rs = bresp;
				break;
			end
		end
		if (k == 50) timeout;
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int k;
		@(posedge clk);
		{araddr, arvalid, rready} <= {a, 2'b11};
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				v = rdata;
				rs = rresp;
				break;
			end
		end
		if (k == 50) timeout;
		rready <= 1'b0;
	endtask
	task wait_halt;
		int k;
		for (k = 0; k < 300; k++) begin
			rd(`RCA_OFS_RUN_SEL, d, r);
			if (d[0] === 1'b0) break;
		end
		if (k == 300) timeout;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_reset;
		rd(`RCA_OFS_RUN_SEL, d, r); `CHK(d, 32'h0)
		`CHK(r, `RCA_RESP_OKAY)
		rd(`RCA_OFS_MODE, d, r); `CHK(d, 32'h0)
		rd(`RCA_OFS_IRQ_STAT, d, r); `CHK(d, 32'h0)
		rd(`RCA_OFS_VECTOR, d, r); `CHK(d[11:0], 12'h02F)
		`CHK(pins.oe, 7'h00)
		`CHK(irq, 1'b0)
		`CHK(vec, 12'h02F)
		$display("t_reset done");
	endtask
	task t_modes;
		logic [6:0] exp_oe [16];
		int m;
		exp_oe = '{1: 7'h09, 2: 7'h0A, 3: 7'h0C, 4: 7'h05, 5: 7'h50, 6: 7'h60, default: 7'h00};
		wr(`RCA_OFS_IRQ_EN, 32'h1, r);
		for (m = 0; m < 16; m++) begin
			wr(`RCA_OFS_MODE, 32'(m), r);
			// gate of exactly 50 system clocks on the decade counter
			wr(`RCA_OFS_CNT_DEC, 32'h0007_9950, r);
			wr(`RCA_OFS_CNT_BIN, 32'h0, r);
			wr(`RCA_OFS_RUN_SEL, 32'h1, r);
			repeat (3) @(posedge clk);
			`CHK(pins.oe, exp_oe[m])
			wait_halt;
			`CHK(irq, 1'b1)
			repeat (3) @(posedge clk);
			`CHK(pins.oe, 7'h00)
			rd(`RCA_OFS_CNT_DEC, d, r); `CHK(d[18:0], 19'h0)
			rd(`RCA_OFS_CNT_BIN, d, r); `CHK(d != 0, m < 8)
			rd(`RCA_OFS_IRQ_STAT, d, r); `CHK(d[1:0], 2'b01)
			wr(`RCA_OFS_IRQ_CLR, 32'h3, r);
			`CHK(irq, 1'b0)
		end
		$display("t_modes done");
	endtask
	task t_bin_gate;
		int k;
		for (k = 0; k < 2; k++) begin
			wr(`RCA_OFS_MODE, k ? 32'h7 : 32'h0, r);
			wr(`RCA_OFS_CNT_DEC, 32'h0007_9990, r);
			wr(`RCA_OFS_CNT_BIN, 32'h0000_3FFC, r);
			wr(`RCA_OFS_RUN_SEL, 32'h3, r);
			wait_halt;
			rd(`RCA_OFS_CNT_BIN, d, r); `CHK(d[13:0], 14'h0)
			rd(`RCA_OFS_IRQ_STAT, d, r); `CHK(d[1:0], 2'b11)
			rd(`RCA_OFS_CNT_DEC, dc, r);
			for (i = 0; i < 5; i++) `CHK(dc[4*i +: 4] <= 4'h9, 1'b1)
			`CHK(dc != 0, 1'b1)
			wr(`RCA_OFS_IRQ_CLR, 32'h3, r);
		end
		$display("t_bin_gate done");
	endtask
	task t_access;
		// mode 8 freezes the binary gate, so this run never ends by itself
		wr(`RCA_OFS_MODE, 32'h8, r);
		wr(`RCA_OFS_CNT_BIN, 32'h0, r);
		wr(`RCA_OFS_RUN_SEL, 32'h3, r);
		wr(`RCA_OFS_CNT_BIN, 32'h1234, r); `CHK(r, `RCA_RESP_OKAY)
		rd(`RCA_OFS_CNT_BIN, d, r); `CHK(d[13:0], 14'h0)
		`CHK(pins.oe, 7'h00)
		wr(`RCA_OFS_RUN_SEL, 32'h0, r);
		rd(`RCA_OFS_CNT_DEC, dc, r);
		repeat (5) @(posedge clk);
		rd(`RCA_OFS_CNT_DEC, d, r); `CHK(d, dc)
		wr(`RCA_OFS_CNT_BIN, 32'h1234, r);
		rd(`RCA_OFS_CNT_BIN, d, r); `CHK(d[13:0], 14'h1234)
		$display("t_access done");
	endtask
	task t_irq;
		wr(`RCA_OFS_CNT_DEC, 32'h0007_9990, r);
		wr(`RCA_OFS_RUN_SEL, 32'h1, r);
		wait_halt;
		wr(`RCA_OFS_IRQ_EN, 32'h0, r); `CHK(irq, 1'b0)
		wr(`RCA_OFS_IRQ_EN, 32'h3, r); `CHK(irq, 1'b1)
		wr(`RCA_OFS_RUN_SEL, 32'h2, r); `CHK(irq, 1'b0)
		wr(`RCA_OFS_RUN_SEL, 32'h0, r); `CHK(irq, 1'b1)
		wr(`RCA_OFS_IRQ_CLR, 32'h1, r); `CHK(irq, 1'b0)
		rd(`RCA_OFS_IRQ_STAT, d, r); `CHK(d[1:0], 2'b00)
		wr(8'h20, 32'h1, r); `CHK(r, `RCA_RESP_SLVERR)
		rd(8'h20, d, r); `CHK(r, `RCA_RESP_SLVERR)
		`CHK(d, 32'h0)
		$display("t_irq done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = '0;
		{bad_count, num_checks} = '0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		t_reset;
		t_modes;
		t_bin_gate;
		t_access;
		t_irq;
		stop_test;
	end
	initial begin
		repeat (100000) @(posedge clk);
		timeout;
	end
endmodule

// ===== verification/rca_rc_net.sv
// behavioural resistor-capacitor network at the oscillator pins
// assumes the block drives exactly the pair that should oscillate
module rca_rc_net #(
	parameter int HALF_NS = 100
) (
	input wire rca_pkg::rca_pins_s osc_pins,
	output logic rc_osc_clock
);
	timeunit 1ns;
	timeprecision 1ns;
	// the network only swings while one pair is driven, so it rests between gates
	initial begin
		rc_osc_clock = 1'b0;
		forever begin
			#(HALF_NS);
			if ($countones(osc_pins.oe) == 2)
				rc_osc_clock = ~rc_osc_clock;
		end
	end
endmodule
